// File: src/periph_irq_pkg.sv
// Register map, field positions and mode codes of the peripheral interrupt flag block.
package periph_irq_pkg;

    // ***************************************************************
    // Register offsets, byte addresses on the APB.
    // ***************************************************************
    localparam logic [7:0] ADDR_FLAGS_1 = 8'h00;
    localparam logic [7:0] ADDR_FLAGS_2 = 8'h04;
    localparam logic [7:0] ADDR_ENABLE_1 = 8'h08;
    localparam logic [7:0] ADDR_ENABLE_2 = 8'h0c;
    localparam logic [7:0] ADDR_CONTROL = 8'h10;

    // ***************************************************************
    // Values after reset and bit masks.
    // ***************************************************************
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] MASK_IMPL_2 = 8'hf5;
    localparam logic [7:0] MASK_WR_1 = 8'hcf;
    localparam logic [7:0] MASK_ALL = 8'hff;
    localparam logic [7:0] MASK_CONTROL = 8'hc0;

    // ***************************************************************
    // Field positions.
    // ***************************************************************
    localparam int BIT_NV_DONE = 7;
    localparam int BIT_ADC_DONE = 6;
    localparam int BIT_RX_FULL = 5;
    localparam int BIT_TX_EMPTY = 4;
    localparam int BIT_CAPCMP_ONE = 2;
    localparam int BIT_CMP_TWO = 6;
    localparam int BIT_CMP_ONE = 5;
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_GROUP_EN = 6;

    // ***************************************************************
    // Capture/compare unit modes.
    // ***************************************************************
    typedef enum logic [1:0] {
        CC_OFF = 2'h0,
        CC_CAPTURE = 2'h1,
        CC_COMPARE = 2'h3,
        CC_PWM = 2'h2
    } capcmp_mode_e;

endpackage : periph_irq_pkg

// File: src/periph_irq_flags.sv
// Peripheral interrupt enable and flag registers with APB access and core request output.
`timescale 1ns/1ps

module periph_irq_flags
    import periph_irq_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic CE_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic NV_WRITE_DONE_IN,
    input wire logic ADC_DONE_IN,
    input wire logic SERIAL_RX_FULL_IN,
    input wire logic SERIAL_TX_EMPTY_IN,
    input wire logic SYNC_SERIAL_DONE_IN,
    input wire logic [1:0] CAPCMP_ONE_MODE_IN,
    input wire logic CAPCMP_ONE_CAPTURE_IN,
    input wire logic CAPCMP_ONE_MATCH_IN,
    input wire logic TIMER_TWO_MATCH_IN,
    input wire logic TIMER_ONE_OVF_IN,
    input wire logic OSC_FAIL_IN,
    input wire logic CMP_TWO_OUTPUT_IN,
    input wire logic CMP_ONE_OUTPUT_IN,
    input wire logic LCD_EVENT_IN,
    input wire logic LOW_VOLT_IN,
    input wire logic [1:0] CAPCMP_TWO_MODE_IN,
    input wire logic CAPCMP_TWO_CAPTURE_IN,
    input wire logic CAPCMP_TWO_MATCH_IN,
    output logic IRQ_OUT
);

    // ***************************************************************
    // Functions.
    // ***************************************************************

    // A capture counts only in capture mode, a match only in compare mode.
    function automatic logic capcmp_event(input logic [1:0] mode, input logic cap,
                                          input logic match);
        capcmp_event = (mode == CC_CAPTURE && cap) || (mode == CC_COMPARE && match);
    endfunction : capcmp_event

    // Hardware set wins over a software write of zero in the same cycle.
    function automatic logic [7:0] reg_update(input logic [7:0] cur, input logic [7:0] set,
                                              input logic wr, input logic [7:0] wdata,
                                              input logic [7:0] mask);
        logic [7:0] base;
        base = wr ? wdata : cur;
        reg_update = (base | set) & mask;
    endfunction : reg_update

    // ***************************************************************
    // Registers.
    // ***************************************************************
    logic [7:0] flags_1;
    logic [7:0] flags_2;
    logic [7:0] enable_1;
    logic [7:0] enable_2;
    logic [7:0] control;
    logic cmp_two_prev;
    logic cmp_one_prev;

    // ***************************************************************
    // APB decode.
    // ***************************************************************
    wire access_done = PSEL_IN && PENABLE_IN && PREADY_OUT;
    wire wr_done = access_done && PWRITE_IN;
    wire hit_flags_1 = (PADDR_IN == ADDR_FLAGS_1);
    wire hit_flags_2 = (PADDR_IN == ADDR_FLAGS_2);
    wire hit_enable_1 = (PADDR_IN == ADDR_ENABLE_1);
    wire hit_enable_2 = (PADDR_IN == ADDR_ENABLE_2);
    wire hit_control = (PADDR_IN == ADDR_CONTROL);
    wire hit_any = hit_flags_1 || hit_flags_2 || hit_enable_1 || hit_enable_2 || hit_control;
    wire [7:0] wdata = PWDATA_IN[7:0];
    wire next_pready = PSEL_IN && PENABLE_IN && !PREADY_OUT;

    // Receive-full and transmit-empty follow their buffers, never stored.
    wire [7:0] flags_1_view = (flags_1 & MASK_WR_1)
        | ({7'h00, SERIAL_RX_FULL_IN} << BIT_RX_FULL)
        | ({7'h00, SERIAL_TX_EMPTY_IN} << BIT_TX_EMPTY);

    logic [7:0] read_byte;
    always_comb begin
        if (hit_flags_1) begin
            read_byte = flags_1_view;
        end else if (hit_flags_2) begin
            read_byte = flags_2;
        end else if (hit_enable_1) begin
            read_byte = enable_1;
        end else if (hit_enable_2) begin
            read_byte = enable_2;
        end else if (hit_control) begin
            read_byte = control;
        end else begin
            read_byte = RST_REG;
        end
    end

    // ***************************************************************
    // Event sources.
    // ***************************************************************
    wire cc_one_set = capcmp_event(CAPCMP_ONE_MODE_IN, CAPCMP_ONE_CAPTURE_IN,
                                   CAPCMP_ONE_MATCH_IN);
    wire cc_two_set = capcmp_event(CAPCMP_TWO_MODE_IN, CAPCMP_TWO_CAPTURE_IN,
                                   CAPCMP_TWO_MATCH_IN);
    wire cmp_two_chg = CMP_TWO_OUTPUT_IN ^ cmp_two_prev;
    wire cmp_one_chg = CMP_ONE_OUTPUT_IN ^ cmp_one_prev;

    // Flags set from events alone, with no enable term.
    wire [7:0] set_1 = {NV_WRITE_DONE_IN, ADC_DONE_IN, 2'b00, SYNC_SERIAL_DONE_IN,
                        cc_one_set, TIMER_TWO_MATCH_IN, TIMER_ONE_OVF_IN};
    wire [7:0] set_2 = {OSC_FAIL_IN, cmp_two_chg, cmp_one_chg, LCD_EVENT_IN, 1'b0,
                        LOW_VOLT_IN, 1'b0, cc_two_set};

    wire [7:0] next_flags_1 = reg_update(flags_1, set_1, wr_done && hit_flags_1, wdata,
                                         MASK_WR_1);
    wire [7:0] next_flags_2 = reg_update(flags_2, set_2, wr_done && hit_flags_2, wdata,
                                         MASK_IMPL_2);
    wire [7:0] next_enable_1 = reg_update(enable_1, RST_REG, wr_done && hit_enable_1, wdata,
                                          MASK_ALL);
    wire [7:0] next_enable_2 = reg_update(enable_2, RST_REG, wr_done && hit_enable_2, wdata,
                                          MASK_IMPL_2);
    wire [7:0] next_control = reg_update(control, RST_REG, wr_done && hit_control, wdata,
                                         MASK_CONTROL);

    // ***************************************************************
    // Request to the core.
    // ***************************************************************
    wire pending = |(flags_1_view & enable_1) || |(flags_2 & enable_2);
    wire next_irq = control[BIT_GLOBAL_EN] && control[BIT_GROUP_EN] && pending;

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            flags_1 <= RST_REG;
            flags_2 <= RST_REG;
            enable_1 <= RST_REG;
            enable_2 <= RST_REG;
            control <= RST_REG;
        end else if (CE_IN) begin
            flags_1 <= next_flags_1;
            flags_2 <= next_flags_2;
            enable_1 <= next_enable_1;
            enable_2 <= next_enable_2;
            control <= next_control;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            cmp_two_prev <= 1'b0;
            cmp_one_prev <= 1'b0;
            IRQ_OUT <= 1'b0;
        end else if (CE_IN) begin
            cmp_two_prev <= CMP_TWO_OUTPUT_IN;
            cmp_one_prev <= CMP_ONE_OUTPUT_IN;
            IRQ_OUT <= next_irq;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
        end else if (CE_IN) begin
            PREADY_OUT <= next_pready;
            PSLVERR_OUT <= next_pready && !hit_any;
            PRDATA_OUT <= next_pready ? {24'h000000, read_byte} : 32'h0000_0000;
        end
    end

    // ***************************************************************
    // Checks.
    // ***************************************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence s_read_flags_1;
        CE_IN && PSEL_IN && PENABLE_IN && !PREADY_OUT && !PWRITE_IN && hit_flags_1;
    endsequence

    sequence s_clear_nv_with_event;
        CE_IN && wr_done && hit_flags_1 && !wdata[BIT_NV_DONE] && NV_WRITE_DONE_IN;
    endsequence

    chk_unimpl_bits_zero: assert property ((enable_2 & ~MASK_IMPL_2) == 8'h00
        && (flags_2 & ~MASK_IMPL_2) == 8'h00)
        else $error("unimplemented bit set");
    chk_adc_flag_set: assert property (CE_IN && ADC_DONE_IN |=> flags_1[BIT_ADC_DONE])
        else $error("conversion flag not set");
    chk_set_beats_clear: assert property (s_clear_nv_with_event |=> flags_1[BIT_NV_DONE])
        else $error("clear beat set");
    chk_nv_flag_held: assert property (flags_1[BIT_NV_DONE] && !(wr_done && hit_flags_1)
        |=> flags_1[BIT_NV_DONE])
        else $error("write-done flag lost");
    chk_rx_read_view: assert property (s_read_flags_1 ##1 PREADY_OUT
        |-> PRDATA_OUT[BIT_RX_FULL] == $past(SERIAL_RX_FULL_IN))
        else $error("receive-full read wrong");
    chk_pwm_no_flag: assert property (CE_IN && CAPCMP_ONE_MODE_IN == CC_PWM
        && !flags_1[BIT_CAPCMP_ONE] && !wr_done |=> !flags_1[BIT_CAPCMP_ONE])
        else $error("flag set in pwm mode");
    chk_cmp_change: assert property (CE_IN && $past(CE_IN) && $changed(CMP_TWO_OUTPUT_IN)
        |=> flags_2[BIT_CMP_TWO])
        else $error("comparator change missed");
    chk_global_gate: assert property (CE_IN && !control[BIT_GLOBAL_EN] |=> !IRQ_OUT)
        else $error("request with global enable clear");
    chk_irq_raise: assert property (CE_IN && control[BIT_GLOBAL_EN] && control[BIT_GROUP_EN]
        && pending |=> IRQ_OUT)
        else $error("request missing");

    // ***************************************************************
    // Checks of the bus handshake, the transmit-empty read view and enable two writes.
    // ***************************************************************
    sequence s_access_wait;
        CE_IN && PSEL_IN && PENABLE_IN && !PREADY_OUT;
    endsequence

    sequence s_write_enable_2;
        CE_IN && wr_done && hit_enable_2;
    endsequence

    chk_ready_after_wait: assert property (s_access_wait |=> PREADY_OUT)
        else $error("ready not raised after wait state");
    chk_ready_one_cycle: assert property (CE_IN && PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    chk_error_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    chk_error_unmapped: assert property (CE_IN && PSEL_IN && PENABLE_IN && !PREADY_OUT
        && !hit_any |=> PSLVERR_OUT)
        else $error("unmapped access without error");
    chk_read_idle_zero: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0000_0000)
        else $error("read data outside a completion");
    chk_tx_read_view: assert property (s_read_flags_1 ##1 PREADY_OUT
        |-> PRDATA_OUT[BIT_TX_EMPTY] == $past(SERIAL_TX_EMPTY_IN))
        else $error("transmit-empty read wrong");
    chk_enable_two_mask: assert property (s_write_enable_2
        |=> enable_2 == ($past(wdata) & MASK_IMPL_2))
        else $error("enable two write wrong");

    // ***************************************************************
    // Checks of the flag set paths, the group gate and flag two writes.
    // ***************************************************************
    chk_nv_flag_set: assert property (CE_IN && NV_WRITE_DONE_IN |=> flags_1[BIT_NV_DONE])
        else $error("write-done flag not set");
    chk_ssp_flag_set: assert property (CE_IN && SYNC_SERIAL_DONE_IN |=> flags_1[3])
        else $error("sync serial flag not set");
    chk_t2_flag_set: assert property (CE_IN && TIMER_TWO_MATCH_IN |=> flags_1[1])
        else $error("timer two flag not set");
    chk_t1_flag_set: assert property (CE_IN && TIMER_ONE_OVF_IN |=> flags_1[0])
        else $error("timer one flag not set");
    chk_osc_flag_set: assert property (CE_IN && OSC_FAIL_IN |=> flags_2[7])
        else $error("oscillator fail flag not set");
    chk_lcd_flag_set: assert property (CE_IN && LCD_EVENT_IN |=> flags_2[4])
        else $error("display flag not set");
    chk_lv_flag_set: assert property (CE_IN && LOW_VOLT_IN |=> flags_2[2])
        else $error("low-voltage flag not set");
    chk_cc_one_capture: assert property (CE_IN && CAPCMP_ONE_MODE_IN == CC_CAPTURE
        && CAPCMP_ONE_CAPTURE_IN |=> flags_1[BIT_CAPCMP_ONE])
        else $error("capture one flag not set");
    chk_cc_one_compare: assert property (CE_IN && CAPCMP_ONE_MODE_IN == CC_COMPARE
        && CAPCMP_ONE_MATCH_IN |=> flags_1[BIT_CAPCMP_ONE])
        else $error("compare one flag not set");
    chk_cc_two_match: assert property (CE_IN && CAPCMP_TWO_MODE_IN == CC_COMPARE
        && CAPCMP_TWO_MATCH_IN |=> flags_2[0])
        else $error("compare two flag not set");
    chk_cmp_one_change: assert property (CE_IN && $past(CE_IN)
        && $changed(CMP_ONE_OUTPUT_IN) |=> flags_2[BIT_CMP_ONE])
        else $error("comparator one change missed");
    chk_group_gate: assert property (CE_IN && !control[BIT_GROUP_EN] |=> !IRQ_OUT)
        else $error("request with group enable clear");
    chk_flag_no_enable: assert property (CE_IN && ADC_DONE_IN
        && !enable_1[BIT_ADC_DONE] |=> flags_1[BIT_ADC_DONE])
        else $error("masked flag not set");
    chk_flags_two_store: assert property (CE_IN && wr_done && hit_flags_2
        && set_2 == 8'h00 |=> flags_2 == ($past(wdata) & MASK_IMPL_2))
        else $error("flag two write wrong");

endmodule : periph_irq_flags

// File: test/irq_event_source.sv
// Model of the peripheral event sources that feed the interrupt flag block.
`timescale 1ns/1ps

module irq_event_source (
    input wire logic CLK_IN,
    output logic [11:0] EVENT_OUT
);
    initial EVENT_OUT = 12'h000;

    // Raises the chosen event lines just after an edge and drops them after the given cycles.
    task automatic fire(input logic [11:0] mask, input int cycles);
        @(posedge CLK_IN);
        EVENT_OUT <= mask;
        repeat (cycles) @(posedge CLK_IN);
        EVENT_OUT <= 12'h000;
    endtask : fire
endmodule : irq_event_source

// File: test/periph_irq_flags_bench.sv
// Self-checking bench for the peripheral interrupt flag block.
`timescale 1ns/1ps

module periph_irq_flags_bench
    import periph_irq_pkg::*;
;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
    logic rx_full, tx_empty, cmp_one, cmp_two;
    logic [1:0] mode_one, mode_two;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [11:0] ev;
    int n_fail, comparisons;
    localparam logic [7:0] ADDRS[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    localparam int EV_BIT[8] = '{7, 6, 3, 1, 0, 7, 4, 2};
    localparam logic [1:0] CMP_SEQ[3] = '{2'b10, 2'b11, 2'b00};
    localparam logic [16:0] IRQ_STEP[4] = '{{ADDR_CONTROL, 8'h40, 1'b0},
        {ADDR_CONTROL, 8'h80, 1'b0}, {ADDR_CONTROL, 8'hc0, 1'b1}, {ADDR_ENABLE_1, 8'h00, 1'b0}};

    periph_irq_flags i_periph_irq_flags (
        .CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(1'b1), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .NV_WRITE_DONE_IN(ev[0]),
        .ADC_DONE_IN(ev[1]), .SERIAL_RX_FULL_IN(rx_full), .SERIAL_TX_EMPTY_IN(tx_empty),
        .SYNC_SERIAL_DONE_IN(ev[2]), .CAPCMP_ONE_MODE_IN(mode_one),
        .CAPCMP_ONE_CAPTURE_IN(ev[8]), .CAPCMP_ONE_MATCH_IN(ev[9]), .TIMER_TWO_MATCH_IN(ev[3]),
        .TIMER_ONE_OVF_IN(ev[4]), .OSC_FAIL_IN(ev[5]), .CMP_TWO_OUTPUT_IN(cmp_two),
        .CMP_ONE_OUTPUT_IN(cmp_one), .LCD_EVENT_IN(ev[6]), .LOW_VOLT_IN(ev[7]),
        .CAPCMP_TWO_MODE_IN(mode_two), .CAPCMP_TWO_CAPTURE_IN(ev[10]),
        .CAPCMP_TWO_MATCH_IN(ev[11]), .IRQ_OUT(irq));
    irq_event_source i_irq_event_source (.CLK_IN(clk), .EVENT_OUT(ev));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        comparisons++;
        if (seen !== expd) begin
            n_fail++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, expd);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, d, output logic [7:0] r,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] expd);
        logic [7:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        check(r, expd);
    endtask : rd_chk

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end

    // ***************************************************************
    // Tests.
    // ***************************************************************
    initial begin
        logic [7:0] a, d, r;
        logic e, h;
        logic [1:0] prev;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {rx_full, tx_empty, cmp_one, cmp_two, mode_one, mode_two} = '0;
        n_fail = 0;
        comparisons = 0;
        rstn = 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        foreach (ADDRS[i]) rd_chk(ADDRS[i], 8'h00);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            a = (i < 5) ? ADDR_FLAGS_1 : ADDR_FLAGS_2;
            i_irq_event_source.fire(12'h001 << i, 1);
            repeat (4) @(posedge clk);
            rd_chk(a, 8'h01 << EV_BIT[i]);
            wr(a, 8'h00);
            rd_chk(a, 8'h00);
        end
        $display("event test done");
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 2; k++) begin
                mode_one <= m[1:0];
                mode_two <= m[1:0];
                i_irq_event_source.fire(k ? 12'ha00 : 12'h500, 1);
                h = (m == (k ? CC_COMPARE : CC_CAPTURE));
                rd_chk(ADDR_FLAGS_1, {5'h0, h, 2'h0});
                rd_chk(ADDR_FLAGS_2, {7'h0, h});
                wr(ADDR_FLAGS_1, 8'h00);
                wr(ADDR_FLAGS_2, 8'h00);
            end
        end
        $display("capture compare test done");
        prev = 2'b00;
        foreach (CMP_SEQ[i]) begin
            {cmp_two, cmp_one} <= CMP_SEQ[i];
            repeat (3) @(posedge clk);
            rd_chk(ADDR_FLAGS_2, {1'b0, CMP_SEQ[i] ^ prev, 5'h00});
            wr(ADDR_FLAGS_2, 8'h00);
            prev = CMP_SEQ[i];
        end
        $display("comparator test done");
        rx_full <= 1'b1;
        tx_empty <= 1'b1;
        wr(ADDR_FLAGS_1, 8'h00);
        rd_chk(ADDR_FLAGS_1, 8'h30);
        wr(ADDR_FLAGS_1, 8'hff);
        rx_full <= 1'b0;
        tx_empty <= 1'b0;
        rd_chk(ADDR_FLAGS_1, 8'hcf);
        wr(ADDR_FLAGS_1, 8'h00);
        wr(ADDR_ENABLE_2, 8'hff);
        rd_chk(ADDR_ENABLE_2, 8'hf5);
        wr(ADDR_FLAGS_2, 8'hff);
        rd_chk(ADDR_FLAGS_2, 8'hf5);
        wr(ADDR_FLAGS_2, 8'h00);
        wr(ADDR_ENABLE_2, 8'h00);
        $display("register access test done");
        wr(ADDR_FLAGS_1, 8'h00);
        wr(ADDR_ENABLE_1, 8'h40);
        wr(ADDR_CONTROL, 8'hc0);
        repeat (2) @(posedge clk);
        check({7'h0, irq}, 8'h00);
        i_irq_event_source.fire(12'h002, 1);
        repeat (3) @(posedge clk);
        check({7'h0, irq}, 8'h01);
        foreach (IRQ_STEP[i]) begin
            {a, d, h} = IRQ_STEP[i];
            wr(a, d);
            repeat (2) @(posedge clk);
            check({7'h0, irq}, {7'h0, h});
        end
        $display("request test done");
        fork
            i_irq_event_source.fire(12'h003, 10);
            begin
                repeat (2) @(posedge clk);
                wr(ADDR_FLAGS_1, 8'h00);
            end
        join
        rd_chk(ADDR_FLAGS_1, 8'hc0);
        apb(1'b0, 8'h14, 8'h00, r, e);
        check({7'h0, e}, 8'h01);
        check(r, 8'h00);
        $display("priority and unmapped test done");
        tally_and_finish();
    end
endmodule : periph_irq_flags_bench
